/* alu_if.sv */
// Carrier between the sequencer and its arithmetic unit.
// Assumes exec_pkg is compiled first.
`timescale 1ns/100ps
`default_nettype none
interface alu_if;
   exec_pkg::op_e                   op;        // Operation in flight
   logic [exec_pkg::WORD_W-1:0]     file_val;  // Addressed file value
   logic [exec_pkg::WORD_W-1:0]     work_val;  // Working register value
   logic                            carry_in;  // Current carry flag
   logic [exec_pkg::WORD_W-1:0]     result;    // Operation result
   logic                            zero;      // Result is zero
   logic                            carry_out; // Carry after rotate

   // Sequencer side drives operands
   modport seq_side (output op, file_val, work_val, carry_in,
                     input  result, zero, carry_out);
   // Arithmetic side returns results
   modport alu_side (input  op, file_val, work_val, carry_in,
                     output result, zero, carry_out);
endinterface : alu_if
`default_nettype wire

/* exec_alu.sv */
// Combinational arithmetic for the file-register operations.
// Assumes operands arrive on alu_if and are stable within the cycle.
`timescale 1ns/100ps
`default_nettype none
module exec_alu (
   alu_if.alu_side bus  // Operands in, results out
);

   // ----------------------------------------------------------------
   // Candidate results
   // ----------------------------------------------------------------
   // increment by one
   wire [exec_pkg::WORD_W-1:0] inc_w = bus.file_val + 8'h01;
   wire [exec_pkg::WORD_W-1:0] or_w  = bus.work_val | bus.file_val;
   // old carry fills the vacated end
   wire [exec_pkg::WORD_W-1:0] rl_w  =
      {bus.file_val[exec_pkg::WORD_W-2:0], bus.carry_in};
   wire [exec_pkg::WORD_W-1:0] rr_w  =
      {bus.carry_in, bus.file_val[exec_pkg::WORD_W-1:1]};

   // ----------------------------------------------------------------
   // Result and flag selection
   // ----------------------------------------------------------------
   assign bus.result =
      (bus.op == exec_pkg::INCREMENT_FILE_OP)     ? inc_w :
      (bus.op == exec_pkg::OR_WORK_WITH_FILE_OP)  ? or_w  :
      (bus.op == exec_pkg::ROTATE_LEFT_CARRY_OP)  ? rl_w  :
      (bus.op == exec_pkg::ROTATE_RIGHT_CARRY_OP) ? rr_w  :
      bus.file_val;
   assign bus.zero = (bus.result == 8'h00);
   // bit pushed out becomes the carry
   assign bus.carry_out =
      (bus.op == exec_pkg::ROTATE_LEFT_CARRY_OP)
         ? bus.file_val[exec_pkg::WORD_W-1] :
      (bus.op == exec_pkg::ROTATE_RIGHT_CARRY_OP)
         ? bus.file_val[0] : bus.carry_in;

endmodule : exec_alu
`default_nettype wire

/* exec_pkg.sv */
// Constants, opcodes and state codes for the instruction execution subset.
// Assumes every user compiles this package first and writes exec_pkg::name.
package exec_pkg;

   // ----------------------------------------------------------------
   // Widths and depths
   // ----------------------------------------------------------------
   localparam int WORD_W      = 8;   // Data path width
   localparam int FADDR_W     = 7;   // File register address width
   localparam int PC_W        = 13;  // Program counter width
   localparam int STACK_DEPTH = 8;   // Hardware call stack levels

   // ----------------------------------------------------------------
   // Destination select encoding
   // ----------------------------------------------------------------
   localparam logic DEST_WORK = 1'b0;  // Result to working register
   localparam logic DEST_FILE = 1'b1;  // Result back to file register

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [WORD_W-1:0] WORK_RST    = 8'h00;   // Working register
   localparam logic [PC_W-1:0]   PC_RST      = 13'h0000; // Reset vector
   localparam logic              CARRY_RST   = 1'b0;    // Carry flag
   localparam logic              ZERO_RST    = 1'b0;    // Zero flag
   localparam logic              PWR_DOWN_RST = 1'b1;   // Power-down flag
   localparam logic              TO_FLAG_RST = 1'b1;    // Time-out flag

   // ----------------------------------------------------------------
   // Values written by the power-down instruction
   // ----------------------------------------------------------------
   localparam logic PWR_DOWN_SLEEP = 1'b0; // Power-down flag on sleep
   localparam logic TO_FLAG_SLEEP = 1'b1;  // Time-out flag on sleep

   // ----------------------------------------------------------------
   // Operation codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      INCREMENT_FILE_OP     = 3'h0,  // File plus one
      OR_WORK_WITH_FILE_OP  = 3'h1,  // Work OR file
      ROTATE_LEFT_CARRY_OP  = 3'h2,  // Rotate left through carry
      ROTATE_RIGHT_CARRY_OP = 3'h3,  // Rotate right through carry
      RETURN_OP             = 3'h4,  // Pop stack into PC
      SLEEP_OP              = 3'h5,  // Enter power-down
      CALL_OP               = 3'h6,  // Push return address, jump
      NOP_OP                = 3'h7   // No operation
   } op_e;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_EXEC  = 2'h0,  // Taking instructions
      ST_FLUSH = 2'h1,  // Second cycle of a return
      ST_SLEEP = 2'h2   // Oscillator halted
   } state_e;

endpackage : exec_pkg

/* instr_exec.sv */
// Execution of a subset of an 8-bit core's instructions: file increment,
// OR with work, rotates through carry, call/return and power-down.
// Assumes file_rdata_i holds the addressed file value while op_valid_i is
// high, and that an outside watchdog obeys the clear pulses.
`timescale 1ns/100ps
`default_nettype none
module instr_exec #(
   parameter int DEPTH = exec_pkg::STACK_DEPTH  // Call stack levels
) (
   input  wire logic                          core_clk_i,     // Clock
   input  wire logic                          rstn_i,         // Sync reset
   input  wire logic                          op_valid_i,     // Op present
   input  wire exec_pkg::op_e                 op_i,           // Opcode
   input  wire logic                          dest_i,         // 1 = file
   input  wire logic [exec_pkg::FADDR_W-1:0]  file_addr_i,    // File addr
   input  wire logic [exec_pkg::WORD_W-1:0]   file_rdata_i,   // File value
   input  wire logic [exec_pkg::PC_W-1:0]     call_target_i,  // Call target
   input  wire logic                          wake_i,         // Leave sleep
   output logic                               op_ready_o,     // Op taken
   output logic                               file_we_o,      // File write
   output logic [exec_pkg::FADDR_W-1:0]       file_waddr_o,   // Write addr
   output logic [exec_pkg::WORD_W-1:0]        file_wdata_o,   // Write data
   output logic [exec_pkg::WORD_W-1:0]        work_o,         // Work reg
   output logic                               carry_o,        // Carry flag
   output logic                               zero_o,         // Zero flag
   output logic [exec_pkg::PC_W-1:0]          pc_o,           // PC
   output logic                               wdt_clear_o,    // Count clr
   output logic                               presc_clear_o,  // Presc clr
   output logic                               power_down_flag_o, // Power-down
   output logic                               timeout_flag_o, // TO bit
   output logic                               sleep_o,        // Asleep
   output logic                               osc_stop_o      // Osc halted
);

   // ----------------------------------------------------------------
   // Local types and constants
   // ----------------------------------------------------------------
   localparam int SP_W = $clog2(DEPTH);             // Stack pointer width
   localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);   // Pointer step

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   exec_pkg::state_e                state_q, state_d;   // Sequencer
   logic [exec_pkg::WORD_W-1:0]     work_q;             // Working register
   logic                            carry_q, zero_q;    // Status flags
   logic [exec_pkg::PC_W-1:0]       pc_q;               // Program counter
   logic [exec_pkg::PC_W-1:0]       stack_q [DEPTH];    // Call stack
   logic [SP_W-1:0]                 sp_q;               // Next free level
   logic                            we_q;               // File write strobe
   logic [exec_pkg::FADDR_W-1:0]    waddr_q;            // File write addr
   logic [exec_pkg::WORD_W-1:0]     wdata_q;            // File write data
   logic                            wdt_clr_q;          // Count clear
   logic                            pwr_dn_q, to_q;     // Power status

   alu_if alu_bus ();   // Operands to the arithmetic unit

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire take_w   = op_valid_i & op_ready_o;             // Op accepted
   wire is_inc_w = (op_i == exec_pkg::INCREMENT_FILE_OP);
   wire is_or_w  = (op_i == exec_pkg::OR_WORK_WITH_FILE_OP);
   wire is_rl_w  = (op_i == exec_pkg::ROTATE_LEFT_CARRY_OP);
   wire is_rr_w  = (op_i == exec_pkg::ROTATE_RIGHT_CARRY_OP);
   wire is_ret_w = (op_i == exec_pkg::RETURN_OP);
   wire is_slp_w = (op_i == exec_pkg::SLEEP_OP);
   wire is_cal_w = (op_i == exec_pkg::CALL_OP);
   wire file_op_w = is_inc_w | is_or_w | is_rl_w | is_rr_w;  // Writes
   wire fop_take_w = take_w & file_op_w;                // File op taken
   wire to_file_w = fop_take_w & (dest_i == exec_pkg::DEST_FILE);
   wire to_work_w = fop_take_w & (dest_i == exec_pkg::DEST_WORK);
   // zero flag only on inc and or
   wire upd_z_w  = take_w & (is_inc_w | is_or_w);
   wire upd_c_w  = take_w & (is_rl_w | is_rr_w);
   wire [SP_W-1:0] top_idx_w = sp_q - SP_ONE;           // Top level
   wire [exec_pkg::PC_W-1:0] stack_top_value = stack_q[top_idx_w];

   // ----------------------------------------------------------------
   // Arithmetic unit
   // ----------------------------------------------------------------
   assign alu_bus.op       = op_i;
   assign alu_bus.file_val = file_rdata_i;
   assign alu_bus.work_val = work_q;
   assign alu_bus.carry_in = carry_q;

   exec_alu u_alu (
      .bus (alu_bus)
   );

   // ----------------------------------------------------------------
   // Sequencer next state
   // ----------------------------------------------------------------
   // Return holds the pipe one extra cycle; sleep waits for wake
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         exec_pkg::ST_EXEC:
         begin
            if (take_w && is_ret_w)
               state_d = exec_pkg::ST_FLUSH;
            else if (take_w && is_slp_w)
               state_d = exec_pkg::ST_SLEEP;
         end
         exec_pkg::ST_FLUSH:
            state_d = exec_pkg::ST_EXEC;    // Fetch slot discarded
         exec_pkg::ST_SLEEP:
            if (wake_i)
               state_d = exec_pkg::ST_EXEC; // Resume on wake
         default:
            state_d = exec_pkg::ST_EXEC;
      endcase
   end

   assign op_ready_o = (state_q == exec_pkg::ST_EXEC);

   // Sequencer register
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
         state_q <= exec_pkg::ST_EXEC;
      else
         state_q <= state_d;
   end

   // ----------------------------------------------------------------
   // Working register and status flags
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         work_q  <= exec_pkg::WORK_RST;
         carry_q <= exec_pkg::CARRY_RST;
         zero_q  <= exec_pkg::ZERO_RST;
      end
      else
      begin
         if (to_work_w)
            work_q <= alu_bus.result;
         if (upd_z_w)
            zero_q <= alu_bus.zero;
         if (upd_c_w)
            carry_q <= alu_bus.carry_out;
      end
   end

   // ----------------------------------------------------------------
   // File write port
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         we_q    <= 1'b0;
         waddr_q <= '0;
         wdata_q <= 8'h00;
      end
      else
      begin
         we_q <= to_file_w;
         if (fop_take_w)
         begin
            waddr_q <= file_addr_i;
            wdata_q <= alu_bus.result;
         end
      end
   end

   // ----------------------------------------------------------------
   // Program counter and call stack
   // ----------------------------------------------------------------
   // Stack wraps silently when overfilled, as a circular buffer
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         pc_q <= exec_pkg::PC_RST;
         sp_q <= '0;
         for (int i = 0; i < DEPTH; i++)
            stack_q[i] <= exec_pkg::PC_RST;
      end
      else if (take_w)
      begin
         if (is_ret_w)
         begin
            pc_q <= stack_top_value;
            sp_q <= top_idx_w;
         end
         else if (is_cal_w)
         begin
            stack_q[sp_q] <= pc_q + 13'h0001;
            sp_q          <= sp_q + SP_ONE;
            pc_q          <= call_target_i;
         end
         else
            pc_q <= pc_q + 13'h0001;      // Sequential fetch
      end
   end

   // ----------------------------------------------------------------
   // Power-down status and watchdog clear
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         wdt_clr_q <= 1'b0;
         pwr_dn_q  <= exec_pkg::PWR_DOWN_RST;
         to_q      <= exec_pkg::TO_FLAG_RST;
      end
      else
      begin
         // clear pulse for count and prescaler
         wdt_clr_q <= take_w & is_slp_w;
         if (take_w && is_slp_w)
         begin
            pwr_dn_q <= exec_pkg::PWR_DOWN_SLEEP;
            to_q <= exec_pkg::TO_FLAG_SLEEP;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign file_we_o         = we_q;
   assign file_waddr_o      = waddr_q;
   assign file_wdata_o      = wdata_q;
   assign work_o            = work_q;
   assign carry_o           = carry_q;
   assign zero_o            = zero_q;
   assign pc_o              = pc_q;
   assign wdt_clear_o       = wdt_clr_q;
   assign presc_clear_o     = wdt_clr_q;
   assign power_down_flag_o = pwr_dn_q;
   assign timeout_flag_o    = to_q;
   assign sleep_o           = (state_q == exec_pkg::ST_SLEEP);
   assign osc_stop_o        = (state_q == exec_pkg::ST_SLEEP);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_DEST_WORK: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      to_work_w |=> !file_we_o && work_o == $past(alu_bus.result))
      else $error("work destination not honoured");

   AST_DEST_FILE: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      to_file_w |=> file_we_o && file_waddr_o == $past(file_addr_i)
         && file_wdata_o == $past(alu_bus.result)
         && work_o == $past(work_q))
      else $error("file destination not honoured");

   AST_INC: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      take_w && is_inc_w |=>
         $past(alu_bus.result) == $past(file_rdata_i) + 8'h01
         && zero_o == ($past(alu_bus.result) == 8'h00) && $stable(carry_o))
      else $error("increment wrong");

   AST_OR: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      take_w && is_or_w |=>
         $past(alu_bus.result) == ($past(work_q) | $past(file_rdata_i))
         && zero_o == ($past(alu_bus.result) == 8'h00) && $stable(carry_o))
      else $error("inclusive OR wrong");

   AST_ROT_LEFT: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      take_w && is_rl_w |=> carry_o == $past(file_rdata_i[7])
         && $past(alu_bus.result) == {$past(file_rdata_i[6:0]),
                                      $past(carry_q)} && $stable(zero_o))
      else $error("rotate left wrong");

   AST_ROT_RIGHT: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      take_w && is_rr_w |=> carry_o == $past(file_rdata_i[0])
         && $past(alu_bus.result) == {$past(carry_q),
                                      $past(file_rdata_i[7:1])}
         && $stable(zero_o))
      else $error("rotate right wrong");

   AST_ROT_ENDS: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      to_file_w && is_rl_w |=> file_wdata_o[0] == $past(carry_q))
      else $error("old carry not rotated in");

   AST_SLEEP_WDT: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      take_w && is_slp_w |=> wdt_clear_o && presc_clear_o ##1 !wdt_clear_o)
      else $error("watchdog not cleared once on sleep");

   AST_SLEEP_FLAGS: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      take_w && is_slp_w |=> !power_down_flag_o && timeout_flag_o)
      else $error("power status wrong after sleep");

   AST_SLEEP_HALT: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      take_w && is_slp_w |=> sleep_o && osc_stop_o && !op_ready_o)
      else $error("sleep state not entered");

   AST_RET_PC: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      take_w && is_ret_w |=> pc_o == $past(stack_top_value)
         && $stable(carry_o) && $stable(zero_o))
      else $error("return did not load stack top");

   AST_RET_TWO: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      take_w && is_ret_w |=> !op_ready_o ##1 op_ready_o)
      else $error("return is not two cycles");

endmodule : instr_exec
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for instr_exec: file ops, call/return and sleep.
// Assumes exec_pkg and the design files are compiled before this one.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic                core_clk = 1'b0;  // 50 MHz core clock
   logic                rstn     = 1'b0;  // Sync reset, active low
   logic                op_valid = 1'b0;  // Op present
   exec_pkg::op_e       op       = exec_pkg::NOP_OP; // Opcode
   logic                dest     = 1'b0;  // Destination select
   logic [6:0]          faddr    = 7'h00; // File address
   logic [7:0]          frdata   = 8'h00; // File value
   logic [12:0]         target   = 13'h0000; // Call target
   logic                wake     = 1'b0;  // Leave sleep
   logic                ready, fwe, carry, zero, wclr, pclr;
   logic                pdf, tof, sleep, oscs;
   logic [6:0]          fwaddr;           // Write address seen
   logic [7:0]          fwdata, work;     // Write data, work reg
   logic [12:0]         pc, ret1, ret2;   // PC and pushed values
   logic [7:0]          ew       = 8'h00; // Expected work
   logic                ec       = 1'b0;  // Expected carry
   logic                ez       = 1'b0;  // Expected zero
   logic [12:0]         epc      = 13'h0000; // Expected pc
   int                  err_total   = 0;  // Mismatches
   int                  check_count = 0;  // Comparisons
   int                  cycles      = 0;  // Timeout counter

   // Clock generator, 20 ns period
   always #10 core_clk = ~core_clk;

   instr_exec #(.DEPTH(8)) DUT (
      .core_clk_i(core_clk), .rstn_i(rstn), .op_valid_i(op_valid),
      .op_i(op), .dest_i(dest), .file_addr_i(faddr),
      .file_rdata_i(frdata), .call_target_i(target), .wake_i(wake),
      .op_ready_o(ready), .file_we_o(fwe), .file_waddr_o(fwaddr),
      .file_wdata_o(fwdata), .work_o(work), .carry_o(carry),
      .zero_o(zero), .pc_o(pc), .wdt_clear_o(wclr),
      .presc_clear_o(pclr), .power_down_flag_o(pdf),
      .timeout_flag_o(tof), .sleep_o(sleep), .osc_stop_o(oscs));

   // ----------------------------------------------------------------
   // Compare, drive and closing tasks
   // ----------------------------------------------------------------
   task automatic cmp_bit(input logic g, input logic e, input string w);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("mismatch at %0t: %s got %b exp %b", $time, w, g, e);
      end
   endtask : cmp_bit

   task automatic cmp_val(input logic [12:0] g, input logic [12:0] e,
                          input string w);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("mismatch at %0t: %s got %h exp %h", $time, w, g, e);
      end
   endtask : cmp_val

   // Present one op just after an edge, then wait for the taking edge
   task automatic drive(input exec_pkg::op_e o, input logic d,
                        input logic [7:0] rd);
      op_valid = 1'b1;
      op       = o;
      dest     = d;
      frdata   = rd;
      faddr    = faddr + 7'h05;
      @(posedge core_clk);
      #1;
   endtask : drive

   // Drop the request for one cycle
   task automatic idle;
      op_valid = 1'b0;
      @(posedge core_clk);
      #1;
   endtask : idle

   // File op with expectations worked out from the old carry and work
   task automatic file_op(input exec_pkg::op_e o, input logic d,
                          input logic [7:0] rd);
      logic [7:0] r;
      r = (o == exec_pkg::INCREMENT_FILE_OP) ? rd + 8'h01 :
          (o == exec_pkg::OR_WORK_WITH_FILE_OP) ? (ew | rd) :
          (o == exec_pkg::ROTATE_LEFT_CARRY_OP) ? {rd[6:0], ec} :
          {ec, rd[7:1]};
      if (o == exec_pkg::INCREMENT_FILE_OP ||
          o == exec_pkg::OR_WORK_WITH_FILE_OP)
         ez = (r == 8'h00);
      else
         ec = (o == exec_pkg::ROTATE_LEFT_CARRY_OP) ? rd[7] : rd[0];
      if (d == exec_pkg::DEST_WORK)
         ew = r;
      epc = epc + 13'h0001;
      drive(o, d, rd);
      cmp_val({5'h00, work}, {5'h00, ew}, "work");
      cmp_bit(carry, ec, "carry");
      cmp_bit(zero, ez, "zero");
      cmp_bit(fwe, d, "file write");
      cmp_val({5'h00, fwdata}, {5'h00, r}, "wdata");
      cmp_val({6'h00, fwaddr}, {6'h00, faddr}, "waddr");
      cmp_val(pc, epc, "pc");
   endtask : file_op

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test

   // Hang guard, far above the 26 or so cycles needed
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         err_total++;
         $display("mismatch at %0t: run timed out", $time);
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge core_clk);
      #1;
      rstn = 1'b1;
      cmp_bit(pdf, exec_pkg::PWR_DOWN_RST, "power-down after reset");
      cmp_bit(ready, 1'b1, "ready after reset");
      $display("test reset done");
      file_op(exec_pkg::OR_WORK_WITH_FILE_OP, 1'b0, 8'h00);
      file_op(exec_pkg::INCREMENT_FILE_OP, 1'b0, 8'h41);
      file_op(exec_pkg::INCREMENT_FILE_OP, 1'b1, 8'hff);
      file_op(exec_pkg::OR_WORK_WITH_FILE_OP, 1'b1, 8'h18);
      file_op(exec_pkg::INCREMENT_FILE_OP, 1'b1, 8'hff);
      $display("test inc_or done");
      // Rotates carry the old carry in, keep zero
      file_op(exec_pkg::ROTATE_LEFT_CARRY_OP, 1'b0, 8'h81);
      file_op(exec_pkg::ROTATE_LEFT_CARRY_OP, 1'b1, 8'h00);
      file_op(exec_pkg::ROTATE_RIGHT_CARRY_OP, 1'b1, 8'h01);
      file_op(exec_pkg::ROTATE_RIGHT_CARRY_OP, 1'b0, 8'h00);
      idle();
      cmp_bit(fwe, 1'b0, "write pulse end");
      $display("test rotate done");
      // Nested calls unwind last in, first out
      ret1 = epc + 13'h0001;
      target = 13'h0123;
      drive(exec_pkg::CALL_OP, 1'b0, 8'h00);
      ret2 = 13'h0124;
      target = 13'h00a5;
      drive(exec_pkg::CALL_OP, 1'b0, 8'h00);
      cmp_val(pc, 13'h00a5, "call target");
      drive(exec_pkg::RETURN_OP, 1'b0, 8'h00);
      cmp_val(pc, ret2, "inner return");
      cmp_bit(ready, 1'b0, "return dead cycle");
      drive(exec_pkg::INCREMENT_FILE_OP, 1'b0, 8'h10);
      cmp_val({5'h00, work}, {5'h00, ew}, "op in dead cycle");
      cmp_val(pc, ret2, "pc held");
      cmp_bit(ready, 1'b1, "ready again");
      drive(exec_pkg::RETURN_OP, 1'b0, 8'h00);
      idle();
      cmp_val(pc, ret1, "outer return");
      cmp_bit(carry, ec, "carry kept");
      cmp_bit(zero, ez, "zero kept");
      epc = ret1;
      $display("test call_return done");
      drive(exec_pkg::SLEEP_OP, 1'b0, 8'h00);
      cmp_bit(wclr, 1'b1, "wdt clear");
      cmp_bit(pclr, 1'b1, "prescaler clear");
      cmp_bit(pdf, exec_pkg::PWR_DOWN_SLEEP, "power-down flag");
      cmp_bit(tof, exec_pkg::TO_FLAG_SLEEP, "to flag");
      cmp_bit(sleep, 1'b1, "asleep");
      cmp_bit(oscs, 1'b1, "osc stopped");
      cmp_bit(ready, 1'b0, "ready asleep");
      cmp_val(pc, epc + 13'h0001, "pc sleep");
      drive(exec_pkg::INCREMENT_FILE_OP, 1'b0, 8'h20);
      cmp_bit(wclr, 1'b0, "wdt clear pulse");
      cmp_val({5'h00, work}, {5'h00, ew}, "op while asleep");
      cmp_bit(oscs, 1'b1, "still stopped");
      wake = 1'b1;
      idle();
      wake = 1'b0;
      cmp_bit(sleep, 1'b0, "awake");
      cmp_bit(pdf, exec_pkg::PWR_DOWN_SLEEP, "power-down kept");
      $display("test sleep done");
      // Mid-run reset restores the power status and the PC
      rstn = 1'b0;
      idle();
      rstn = 1'b1;
      cmp_bit(pdf, exec_pkg::PWR_DOWN_RST, "power-down on reset");
      cmp_val(pc, exec_pkg::PC_RST, "pc on reset");
      cmp_bit(ready, 1'b1, "ready on reset");
      $display("test reset_again done");
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
